// file: src/ttc_pkg.sv
// Constants and types shared by the tamper time-stamp clock core
package ttc_pkg;
  localparam int CLK_HZ      = 100_000_000;
  localparam int TICK_HZ     = 100;         // Hundredths-of-second tick
  localparam int WIPE_DLY_US = 1500;        // Wipe delay, inside 1.0..2.0 ms
  localparam int WIPE_DOF_US = 500;         // Wipe delay with osc fail set
  localparam int SAMPLE_US   = 1000;        // Length of one sample window
  localparam int TICK_CYC    = CLK_HZ / TICK_HZ;
  localparam int WIPE_DLY_CYC = CLK_HZ / 1_000_000 * WIPE_DLY_US;
  localparam int WIPE_DOF_CYC = CLK_HZ / 1_000_000 * WIPE_DOF_US;
  localparam int SAMPLE_CYC  = CLK_HZ / 1_000_000 * SAMPLE_US;
  localparam int CNT_W       = 24;
  // Wipe widths in ticks: 1, 4, 8, 16 s
  localparam logic [CNT_W-1:0] WIPE_W0 = 24'h000064;
  localparam logic [CNT_W-1:0] WIPE_W1 = 24'h000190;
  localparam logic [CNT_W-1:0] WIPE_W2 = 24'h000320;
  localparam logic [CNT_W-1:0] WIPE_W3 = 24'h000640;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CLK_LAST = 8'h07;
  localparam logic [7:0] IDX_FREEZE   = 8'h0c;
  localparam logic [7:0] IDX_FLAGS    = 8'h0f;
  localparam logic [7:0] IDX_TAMP1    = 8'h14;
  localparam logic [7:0] IDX_TAMP2    = 8'h15;
  localparam logic [7:0] IDX_RAM_LO   = 8'h20;
  localparam logic [7:0] IDX_RAM_HI   = 8'h9f;
  // Bit positions
  localparam int B_OSC_HALT = 7;   // In clock byte 01h
  localparam int B_FREEZE   = 6;   // In index 0Ch
  localparam int B_OF       = 2;   // Flags: osc fail; D1 ch0, D0 ch1
  localparam int B_ARM      = 7;   // Tamper control byte fields
  localparam int B_IE       = 6;
  localparam int B_MODE     = 5;
  localparam int B_TRIG     = 4;
  localparam int B_SAMP     = 3;
  localparam int B_PSTR     = 2;
  localparam int B_OFFCHIP  = 1;
  localparam int B_ONCHIP   = 0;
  localparam int B_WW0      = 4;   // Wipe width in clock byte 04h
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Reset values of the clock bytes
  localparam logic [7:0] RST_DAY  = 8'h01;
  localparam logic [7:0] RST_DATE = 8'h01;
  localparam logic [7:0] RST_MON  = 8'h01;

  typedef enum logic [2:0] {
    WP_IDLE  = 3'b001,
    WP_DELAY = 3'b010,
    WP_DRIVE = 3'b100
  } ttc_wipe_t;

  typedef struct packed {
    logic [2:0]            ps1;
    logic [2:0]            ps2;
    logic [2:0]            ps3;
    logic [2:0]            lvl;
    logic [7:0][7:0]       tm;
    logic [7:0][7:0]       ext;
    logic [CNT_W-1:0]      div;
    logic [CNT_W-1:0]      smp;
    logic [CNT_W-1:0]      wcnt;
    logic [1:0][7:0]       tctl;
    logic [1:0]            flag;
    logic [1:0]            irqp;
    logic [1:0]            rinv;
    logic                  of;
    logic                  frz;
    logic                  pwr;
    ttc_wipe_t             wst;
    logic [127:0][7:0]     ram;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
    logic                  irq_n;
    logic                  rst_n;
    logic                  wipe;
    logic [1:0]            pen;
    logic [1:0]            pup;
    logic [1:0]            pstr;
  } ttc_state_t;
endpackage

// file: src/ttc_core.sv
// Tamper detection, wipe and time-stamp clock core with AXI4-Lite regs
`timescale 1ns/1ps
module ttc_core #(
  parameter int TICK_CYC_P = ttc_pkg::TICK_CYC,
  parameter int WDLY_CYC_P = ttc_pkg::WIPE_DLY_CYC,
  parameter int WDOF_CYC_P = ttc_pkg::WIPE_DOF_CYC,
  parameter int SMP_CYC_P  = ttc_pkg::SAMPLE_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  tamper_input_pin,
  input  wire logic        power_fail_in,
  output logic             irq_out_n,
  output logic             rst_out_n,
  output logic             wipe_drive_output,
  output logic [1:0]       pull_enable,
  output logic [1:0]       pull_up,
  output logic [1:0]       pull_strength_select
);
  import ttc_pkg::*;

  ttc_state_t s;
  ttc_state_t next_s;

  // BCD increment with wrap from lim back to lo
  function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] lim,
                                         input logic [7:0] lo);
    if (v >= lim) begin
      return lo;
    end
    if (v[3:0] >= 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Last date of a month, leap years every fourth BCD year
  function automatic logic [7:0] month_end(input logic [7:0] mon,
                                           input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                    yr[3:0] == 4'h8);
    if (mon == 8'h02) begin
      return leap ? 8'h29 : 8'h28;
    end
    if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 ||
        mon == 8'h11) begin
      return 8'h30;
    end
    return 8'h31;
  endfunction

  // Advance the internal time by one hundredth; control bits kept
  function automatic logic [7:0][7:0] time_inc(
      input logic [7:0][7:0] t);
    logic [7:0][7:0] r;
    logic            c;
    r = t;
    r[0] = bcd_inc(t[0], 8'h99, 8'h00);
    c = (t[0] == 8'h99);
    if (c) begin
      r[1][6:0] = 7'(bcd_inc({1'b0, t[1][6:0]}, 8'h59, 8'h00));
      c = (t[1][6:0] == 7'h59);
    end
    if (c) begin
      r[2][6:0] = 7'(bcd_inc({1'b0, t[2][6:0]}, 8'h59, 8'h00));
      c = (t[2][6:0] == 7'h59);
    end
    if (c) begin
      r[3][5:0] = 6'(bcd_inc({2'b0, t[3][5:0]}, 8'h23, 8'h00));
      c = (t[3][5:0] == 6'h23);
    end
    if (c) begin
      r[4][2:0] = 3'(bcd_inc({5'b0, t[4][2:0]}, 8'h07, 8'h01));
      r[5][5:0] = 6'(bcd_inc({2'b0, t[5][5:0]},
                     month_end({3'b0, t[6][4:0]}, t[7]), 8'h01));
      c = ({2'b0, t[5][5:0]} >= month_end({3'b0, t[6][4:0]}, t[7]));
    end
    if (c) begin
      r[6][4:0] = 5'(bcd_inc({3'b0, t[6][4:0]}, 8'h12, 8'h01));
      c = (t[6][4:0] == 5'h12);
    end
    if (c) begin
      r[7] = bcd_inc(t[7], 8'h99, 8'h00);
      c = (t[7] == 8'h99);
    end
    if (c) begin
      r[3][7:6] = t[3][7:6] + 2'h1; // Century rolls with the year
    end
    return r;
  endfunction

  // Address decode shared by the read and write channels
  function automatic logic mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    if (a[11:10] != 2'b00) begin
      return 1'b0;
    end else if (i <= IDX_CLK_LAST) begin
      return 1'b1;
    end else if (i == IDX_FREEZE || i == IDX_FLAGS) begin
      return 1'b1;
    end else if (i == IDX_TAMP1 || i == IDX_TAMP2) begin
      return 1'b1;
    end else if (i >= IDX_RAM_LO && i <= IDX_RAM_HI) begin
      return 1'b1;
    end
    return 1'b0;
  endfunction

  // Whole next state
  always_comb begin
    logic       tick;
    logic       osc_on;
    logic       any_arm;
    logic       frozen;
    logic       rd_clk;
    logic       win;
    logic       wr_go;
    logic [7:0] wi;
    logic [7:0] ri;
    logic [7:0] wd;
    logic [1:0] ev;
    logic [6:0] ro;
    tick = 1'b0;
    ev = 2'b00;
    wi = s_axi_awaddr[9:2];
    ri = s_axi_araddr[9:2];
    wd = s_axi_wdata[7:0];
    ro = 7'(ri - IDX_RAM_LO);
    win = 1'b0;
    osc_on = !s.tm[1][B_OSC_HALT];
    any_arm = s.tctl[0][B_ARM] || s.tctl[1][B_ARM];
    frozen = (s.flag != 2'b00) || s.frz;
    rd_clk = s_axi_arvalid && (s_axi_araddr[11:10] == 2'b00) &&
             (ri <= IDX_CLK_LAST);
    wr_go = s_axi_awvalid && s_axi_wvalid && !s.awready && !s.bvalid;
    next_s = s;

    // Three-stage pin sync; level taken when stages two and three agree
    next_s.ps1 = {power_fail_in, tamper_input_pin};
    next_s.ps2 = s.ps1;
    next_s.ps3 = s.ps2;
    for (int i = 0; i < 3; i++) begin
      if (s.ps2[i] == s.ps3[i]) begin
        next_s.lvl[i] = s.ps3[i];
      end
    end

    // Divider runs only while the oscillator is not halted
    if (osc_on) begin
      if (s.div >= CNT_W'(TICK_CYC_P - 1)) begin
        next_s.div = '0;
        tick = 1'b1;
      end else begin
        next_s.div = s.div + 1'b1;
      end
    end
    if (tick) begin
      next_s.tm = time_inc(s.tm);
    end

    // Sample window opens at each whole second
    if (tick && s.tm[0] == 8'h99) begin
      next_s.smp = CNT_W'(SMP_CYC_P);
    end else if (s.smp != '0) begin
      next_s.smp = s.smp - 1'b1;
    end

    // Wipe sequencer; wait counted in aclk cycles, width in hundredth ticks
    case (s.wst)
      WP_IDLE: begin
      end
      WP_DELAY: begin
        if (s.wcnt == '0) begin
          next_s.wst = WP_DRIVE;
          case (s.tm[4][B_WW0+1:B_WW0])
            2'b00:   next_s.wcnt = WIPE_W0;
            2'b01:   next_s.wcnt = WIPE_W1;
            2'b10:   next_s.wcnt = WIPE_W2;
            default: next_s.wcnt = WIPE_W3;
          endcase
        end else begin
          next_s.wcnt = s.wcnt - 1'b1;
        end
      end
      WP_DRIVE: begin
        if (tick) begin
          if (s.wcnt <= 24'h000001) begin
            next_s.wst = WP_IDLE;
            next_s.wcnt = '0;
          end else begin
            next_s.wcnt = s.wcnt - 1'b1;
          end
        end
      end
      default: begin
        next_s.wst = WP_IDLE;
      end
    endcase

    // Write channel: address and data taken together, one at a time
    next_s.awready = wr_go;
    next_s.wready = wr_go;
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.awready) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (mapped(s_axi_awaddr) && s_axi_wstrb[0]) begin
        if (wi <= IDX_CLK_LAST) begin
          // Hundredths always forced to zero on any clock write
          next_s.tm[wi[2:0]] = wd;
          next_s.ext[wi[2:0]] = wd;
          next_s.tm[0] = 8'h00;
          next_s.ext[0] = 8'h00;
          next_s.div = '0;
        end else if (wi == IDX_FREEZE) begin
          next_s.frz = wd[B_FREEZE];
        end else if (wi == IDX_FLAGS) begin
          if (!wd[B_OF]) begin
            next_s.of = 1'b0;
          end
        end else if (wi == IDX_TAMP1 || wi == IDX_TAMP2) begin
          next_s.tctl[wi[0]] = wd;
          if (!wd[B_ARM]) begin
            next_s.flag[wi[0]] = 1'b0;
            next_s.rinv[wi[0]] = 1'b0;
          end
          if (!wd[B_IE]) begin
            next_s.irqp[wi[0]] = 1'b0;
          end
        end else if (s.rinv == 2'b00) begin
          next_s.ram[7'(wi - IDX_RAM_LO)] = wd;
        end
      end
    end

    // Read channel; a flags read also retires the tamper interrupt
    next_s.arready = s_axi_arvalid && !s.arready && !s.rvalid;
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_s.rdata = '0;
      if (!mapped(s_axi_araddr)) begin
        next_s.rdata = '0;
      end else if (ri <= IDX_CLK_LAST) begin
        next_s.rdata[7:0] = s.ext[ri[2:0]];
      end else if (ri == IDX_FREEZE) begin
        next_s.rdata[B_FREEZE] = s.frz;
      end else if (ri == IDX_FLAGS) begin
        next_s.rdata[B_OF] = s.of;
        next_s.rdata[1] = s.flag[0];
        next_s.rdata[0] = s.flag[1];
        next_s.irqp = 2'b00;
      end else if (ri == IDX_TAMP1 || ri == IDX_TAMP2) begin
        next_s.rdata[7:0] = s.tctl[ri[0]];
      end else begin
        // Wiped RAM reads all ones until its channel is disarmed
        next_s.rdata[7:0] = (s.rinv != 2'b00) ? 8'hff : s.ram[ro];
      end
    end

    // Tamper detection per channel, independent of supply state
    for (int i = 0; i < 2; i++) begin
      win = s.tctl[i][B_MODE] || !s.tctl[i][B_SAMP] || !osc_on ||
            (s.smp != '0);
      // Both switch modes end with the pin at the trigger level
      ev[i] = s.tctl[i][B_ARM] && !s.flag[i] && win &&
              (s.lvl[i] == s.tctl[i][B_TRIG]);
      next_s.pen[i] = s.tctl[i][B_ARM] && !s.flag[i] &&
                      !s.tctl[i][B_MODE] && win;
      next_s.pup[i] = s.tctl[i][B_TRIG];
      next_s.pstr[i] = s.tctl[i][B_PSTR];
      if (ev[i]) begin
        next_s.flag[i] = 1'b1;
        if (s.tctl[i][B_IE]) begin
          next_s.irqp[i] = 1'b1;
        end
        if (s.tctl[i][B_ONCHIP]) begin
          next_s.ram = '0;
          next_s.rinv[i] = 1'b1;
        end
        if (s.tctl[i][B_OFFCHIP] && s.wst == WP_IDLE) begin
          next_s.wst = WP_DELAY;
          next_s.wcnt = s.of ? CNT_W'(WDOF_CYC_P - 1)
                             : CNT_W'(WDLY_CYC_P - 1);
        end
      end
    end

    // Power returning sets the freeze bit unless a channel is armed
    next_s.pwr = s.lvl[2];
    if (s.pwr && !s.lvl[2] && !any_arm) begin
      next_s.frz = 1'b1;
    end
    if (!osc_on) begin
      next_s.of = 1'b1; // Stopped oscillator is reported as failed
    end

    // Readable copy follows the count unless frozen, being read or being written
    if (frozen) begin
      next_s.ext[0] = 8'h00;
    end else if (!rd_clk && !s.awready) begin
      next_s.ext = next_s.tm;
    end

    // Pin drivers, each from its own flop
    next_s.wipe = (next_s.wst == WP_DRIVE);
    next_s.rst_n = !(next_s.wst == WP_DRIVE) && !s.lvl[2];
    if (!next_s.rst_n && s.rst_n) begin
      next_s.irqp = 2'b00;
    end
    next_s.irq_n = (next_s.irqp == 2'b00);
  end

  // State register; reset stands for a power-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.tm[4] <= RST_DAY;
      s.tm[5] <= RST_DATE;
      s.tm[6] <= RST_MON;
      s.ext[4] <= RST_DAY;
      s.ext[5] <= RST_DATE;
      s.ext[6] <= RST_MON;
      s.frz <= 1'b1;
      s.wst <= WP_IDLE;
      s.irq_n <= 1'b1;
      s.rst_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign irq_out_n = s.irq_n;
  assign rst_out_n = s.rst_n;
  assign wipe_drive_output = s.wipe;
  assign pull_enable = s.pen;
  assign pull_up = s.pup;
  assign pull_strength_select = s.pstr;
endmodule

// file: tb/ttc_switch_model.sv
// Model of the two external tamper switches and their pin wiring
`timescale 1ns/1ps
module ttc_switch_model (
  input  wire logic [1:0] sw_closed,
  input  wire logic [1:0] norm_open,
  input  wire logic [1:0] trig_lvl,
  input  wire logic       aclk,
  input  wire logic [1:0] pull_enable,
  input  wire logic [1:0] pull_up,
  output logic [1:0]      tamper_input_pin
);
  logic [1:0] pin_q = 2'b00;
  // An undriven pin drifts each cycle so a stale level is never trusted
  always @(posedge aclk) begin
    for (int c = 0; c < 2; c++) begin
      if (norm_open[c])
        pin_q[c] <= sw_closed[c] ? trig_lvl[c] : ~trig_lvl[c];
      else if (sw_closed[c])
        pin_q[c] <= ~trig_lvl[c];
      else if (pull_enable[c])
        pin_q[c] <= pull_up[c];
      else
        pin_q[c] <= ~pin_q[c];
    end
  end
  assign tamper_input_pin = pin_q;
endmodule

// file: tb/ttc_core_chk.sv
// Port-level timing checks for the tamper time-stamp clock core
`timescale 1ns/1ps
module ttc_core_chk #(
  parameter int TICK_CYC_P = 20
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq_out_n,
  input wire logic        rst_out_n,
  input wire logic        wipe_drive_output
);
  localparam int MIN_W = 99 * TICK_CYC_P;
  int wcnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Length of the current wipe pulse; tick alignment costs one tick
  always_ff @(posedge aclk) begin
    if (aresetn && wipe_drive_output)
      wcnt <= wcnt + 1;
    else
      wcnt <= 0;
  end
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  a_wr_answer: assert property (s_axi_awready |-> s_axi_wready ##1 s_axi_bvalid)
    else $error("write answer late");
  a_rd_take: assert property
    (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready)
    else $error("read address not taken");
  a_rd_answer: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wipe_rst: assert property (wipe_drive_output |-> !rst_out_n)
    else $error("wipe without reset output");
  a_wipe_len: assert property ($fell(wipe_drive_output) |-> wcnt >= MIN_W)
    else $error("wipe pulse too short");
  a_rst_irq: assert property ($fell(rst_out_n) |-> ##[0:2] irq_out_n)
    else $error("interrupt kept across reset output");
  a_flag_read: assert property
    (s_axi_arready && s_axi_araddr == 12'h03c |-> ##[1:3] irq_out_n)
    else $error("interrupt kept after flags read");
  c_wipe: cover property ($rose(wipe_drive_output));
  c_irq: cover property ($fell(irq_out_n));
  c_flags: cover property (s_axi_arready && s_axi_araddr == 12'h03c);
endmodule

// file: tb/ttc_core_tb_top.sv
// Self-checking bench for the tamper time-stamp clock core
`timescale 1ns/1ps
module ttc_core_tb_top;
  import ttc_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        power_fail_in = 1'b0;
  logic [1:0]  sw_closed = 2'b00;
  logic [1:0]  norm_open = 2'b00;
  logic [1:0]  trig_lvl = 2'b00;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic        irq_out_n, rst_out_n, wipe_drive_output;
  logic [1:0]  s_axi_bresp, s_axi_rresp, tamper_input_pin;
  logic [1:0]  pull_enable, pull_up, pull_strength_select, rsp;
  logic [31:0] s_axi_rdata, rd;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          d;
  int          w;
  int          secs[4] = '{1, 4, 8, 16};
  localparam int TK = 20;
  localparam int DLY = 15;
  localparam int DOF = 5;
  // Window must outlast pin sync plus pull turn-on, about six cycles
  localparam int SMP = 10;

  ttc_core #(.TICK_CYC_P(TK), .WDLY_CYC_P(DLY), .WDOF_CYC_P(DOF),
    .SMP_CYC_P(SMP)) ttc_core_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tamper_input_pin, .power_fail_in, .irq_out_n, .rst_out_n,
    .wipe_drive_output, .pull_enable, .pull_up, .pull_strength_select);
  ttc_switch_model ttc_switch_model_inst (.sw_closed, .norm_open,
    .trig_lvl, .aclk, .pull_enable, .pull_up, .tamper_input_pin);

  // Free-running 100 MHz clock
  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rng(input string nm, input int lo, input int hi,
                     input int g);
    n_tests++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Bus cycles: ready and valid are looked at where they are settled
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (s_axi_awready !== 1'b1);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] i);
    @(posedge aclk);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard, well above the longest expected run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(8'h0c);
    chk("freeze", 32'h40, rd & 32'h40);
    rdr(8'h05);
    chk("date", 32'h01, rd);
    rdr(8'h10);
    chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    wr(8'h10, 8'h00);
    chk("bresp_err", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    wr(8'h0c, 8'h00);
    chk("bresp_ok", {30'h0, RESP_OKAY}, {30'h0, rsp});
    wr(8'h03, 8'hc5);
    wr(8'h07, 8'h99);
    rdr(8'h03);
    chk("century", 32'hc5, rd);
    rdr(8'h07);
    chk("year", 32'h99, rd);
    wr(8'h00, 8'h55);
    rdr(8'h00);
    chk("hundredths", 32'h00, rd);
    $display("test clock_bus done");
    // Two normally-open tampers; the stamp must keep the first one
    norm_open <= 2'b11;
    trig_lvl <= 2'b01;
    wr(8'h01, 8'h30);
    wr(8'h14, 8'hf0);
    wr(8'h15, 8'ha0);
    sw_closed <= 2'b01;
    repeat (10) @(negedge aclk);
    chk("irq", 32'h0, {31'h0, irq_out_n});
    rdr(8'h00);
    chk("frozen_hund", 32'h00, rd);
    rdr(8'h0f);
    chk("flags", 32'h02, rd);
    repeat (4) @(negedge aclk);
    chk("irq_clear", 32'h1, {31'h0, irq_out_n});
    wr(8'h0f, 8'hff);
    sw_closed <= 2'b11;
    repeat (4000) @(negedge aclk);
    rdr(8'h0f);
    chk("flags_ro", 32'h03, rd);
    rdr(8'h01);
    chk("stamp", 32'h30, rd);
    wr(8'h14, 8'h00);
    rdr(8'h01);
    chk("stamp_one_armed", 32'h30, rd);
    wr(8'h15, 8'h00);
    sw_closed <= 2'b00;
    rdr(8'h0f);
    chk("flags_clr", 32'h00, rd);
    rdr(8'h01);
    chk("resumed", 32'h32, rd);
    $display("test time_stamp done");
    // Normally-closed channel sampled once a second
    sw_closed <= 2'b10;
    norm_open <= 2'b00;
    trig_lvl <= 2'b10;
    wr(8'h15, 8'h9c);
    @(negedge aclk);
    chk("pull_cfg", 32'h3,
        {30'h0, pull_strength_select[1], pull_up[1]});
    w = 0;
    repeat (2000) begin
      @(negedge aclk);
      w += int'(pull_enable[1]);
    end
    rng("sample_len", SMP, SMP, w);
    sw_closed <= 2'b00;
    repeat (2100) @(negedge aclk);
    rdr(8'h0f);
    chk("nc_flag", 32'h01, rd);
    wr(8'h15, 8'h00);
    $display("test sampling done");
    // Off-chip and on-chip wipe for every width code
    norm_open <= 2'b01;
    trig_lvl <= 2'b01;
    for (int i = 0; i < 4; i++) begin
      if (i == 0) begin
        wr(8'h01, 8'h80);
        wr(8'h01, 8'h00);
      end
      wr(8'h04, {2'b00, i[1:0], 4'h1});
      wr(8'h20, 8'h5a);
      wr(8'h14, 8'hb3);
      sw_closed <= 2'b01;
      d = 0;
      do begin
        @(negedge aclk);
        d++;
      end while (wipe_drive_output !== 1'b1);
      rng("wipe_delay", i == 0 ? DOF : DLY,
          i == 0 ? DOF + 8 : DLY + 8, d);
      chk("rst_out", 32'h0, {31'h0, rst_out_n});
      w = 0;
      while (wipe_drive_output === 1'b1) begin
        @(negedge aclk);
        w++;
      end
      rng("wipe_len", secs[i] * 100 * TK - TK,
          secs[i] * 100 * TK + TK, w);
      sw_closed <= 2'b00;
      rdr(8'h20);
      chk("ram_invalid", 32'hff, rd);
      if (i == 0) begin
        rdr(8'h0f);
        chk("osc_fail", 32'h06, rd);
        wr(8'h0f, 8'h00);
      end
      wr(8'h14, 8'h00);
      rdr(8'h20);
      chk("ram_wiped", 32'h00, rd);
    end
    $display("test wipe done");
    // Power fail, first armed with a tamper inside it, then unarmed
    for (int j = 0; j < 2; j++) begin
      wr(8'h14, j == 0 ? 8'hb0 : 8'h00);
      power_fail_in <= 1'b1;
      sw_closed <= j == 0 ? 2'b01 : 2'b00;
      repeat (10) @(negedge aclk);
      chk("pfail_rst", 32'h0, {31'h0, rst_out_n});
      @(posedge aclk);
      power_fail_in <= 1'b0;
      repeat (10) @(negedge aclk);
      rdr(8'h0c);
      chk("pfail_freeze", j == 0 ? 32'h0 : 32'h40, rd & 32'h40);
      rdr(8'h0f);
      chk("pfail_flags", j == 0 ? 32'h02 : 32'h00, rd);
      sw_closed <= 2'b00;
      wr(8'h14, 8'h00);
    end
    $display("test power_fail done");
    give_verdict();
  end
endmodule

bind ttc_core ttc_core_chk #(.TICK_CYC_P(TICK_CYC_P)) ttc_core_chk_inst (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .irq_out_n, .rst_out_n,
  .wipe_drive_output);
